// file: eep_ctrl.sv
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "eep_cfg.svh"

module eep_ctrl import eep_pkg::*; #(
  parameter int ADDR_W         = 8,
  parameter int SK_HALF        = `EEP_SK_HALF_CYC,
  parameter int TIMEOUT_CYCLES = `EEP_TIMEOUT_MS * (`EEP_CLK_HZ / 1000)
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   eepCs,
  output logic                   eepSk,
  output logic                   eepDi,
  input  wire logic              eepDo
);

  localparam int DIV_W = (SK_HALF > 1) ? $clog2(SK_HALF) : 1;
  localparam int TO_W  = $clog2(TIMEOUT_CYCLES + 1);

  logic [ADDR_W-1:0] awAddr_q;
  logic              awHeld_q;
  logic [31:0]       wData_q;
  logic [3:0]        wStrb_q;
  logic              wHeld_q;
  logic              wrFire;
  logic              wrCmd;
  logic              wrData;
  logic [2:0]        opc_q;
  logic [8:0]        addr_q;
  logic [7:0]        buffer_q;
  logic              busy_q;
  logic              loaded_q;
  logic              tmo_q;
  logic              bootPend_q;
  logic              swStart;
  logic              launch;
  eep_op_e           launchOp;
  logic [8:0]        launchAddr;
  eep_state_e        state_q;
  eep_op_e           curOp_q;
  logic [19:0]       frame_q;
  logic [7:0]        shIn_q;
  logic [4:0]        bitCnt_q;
  logic [4:0]        nBits_q;
  logic [DIV_W-1:0]  divCnt_q;
  logic              tick;
  logic [TO_W-1:0]   toCnt_q;
  logic              toHit;
  logic              doSync;

  // ==========================================================================
  // Decode helpers.
  // Address decode ignores the two byte-offset bits, so any byte address in
  // the word hits the register.
  function automatic logic [1:0] regSel(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'h0};
    if (w == ADDR_W'(`EEP_CMD_OFS)) begin
      regSel = 2'h1;
    end else if (w == ADDR_W'(`EEP_DATA_OFS)) begin
      regSel = 2'h2;
    end else begin
      regSel = 2'h0;
    end
  endfunction

  // Ops that carry eight data bits in or out use a 20-clock frame.
  function automatic logic longFrame(input eep_op_e op);
    longFrame = (op == EEP_OP_READ) || (op == EEP_OP_WRITE) ||
                (op == EEP_OP_WRITE_ALL_CMD) || (op == EEP_OP_RELOAD);
  endfunction

  // Programming ops need a ready/busy poll after the frame.
  function automatic logic needsPoll(input eep_op_e op);
    needsPoll = (op == EEP_OP_WRITE) || (op == EEP_OP_WRITE_ALL_CMD) ||
                (op == EEP_OP_ERASE) || (op == EEP_OP_ERASE_ALL_CMD);
  endfunction

  // Serial frame, MSB first: start bit, two opcode bits, nine address bits,
  // then eight data bits where the op has them.
  function automatic logic [19:0] buildFrame(input eep_op_e op, input logic [8:0] a,
                                             input logic [7:0] d);
    case (op)
      EEP_OP_READ:   buildFrame = {3'h6, a, 8'h00};
      EEP_OP_ERASE_WRITE_DISABLE_CMD:   buildFrame = {3'h4, 9'h000, 8'h00};
      EEP_OP_ERASE_WRITE_ENABLE_CMD:   buildFrame = {3'h4, 9'h180, 8'h00};
      EEP_OP_WRITE:  buildFrame = {3'h5, a, d};
      EEP_OP_WRITE_ALL_CMD:   buildFrame = {3'h4, 9'h080, d};
      EEP_OP_ERASE:  buildFrame = {3'h7, a, 8'h00};
      EEP_OP_ERASE_ALL_CMD:   buildFrame = {3'h4, 9'h100, 8'h00};
      EEP_OP_RELOAD: buildFrame = {3'h6, 9'h000, 8'h00};
      default:       buildFrame = 20'h0_0000;
    endcase
  endfunction

  // ==========================================================================
  // AXI4-Lite write channels: address and data are taken independently.
  assign wrFire = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign wrCmd  = wrFire && (regSel(awAddr_q) == 2'h1);
  assign wrData = wrFire && (regSel(awAddr_q) == 2'h2);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_q      <= 1'b0;
      awAddr_q      <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_q      <= 1'b1;
      awAddr_q      <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wrFire) begin
      awHeld_q      <= 1'b0;
      s_axi_awready <= 1'b1;
    end else if (!awHeld_q) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wHeld_q      <= 1'b0;
      wData_q      <= '0;
      wStrb_q      <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_q      <= 1'b1;
      wData_q      <= s_axi_wdata;
      wStrb_q      <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wrFire) begin
      wHeld_q      <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (!wHeld_q) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Unmapped writes are dropped and answered with SLVERR.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `EEP_RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (regSel(awAddr_q) == 2'h0) ? `EEP_RESP_SLVERR : `EEP_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel: one cycle from address to data, no side effects.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `EEP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `EEP_RESP_OKAY;
      case (regSel(s_axi_araddr))
        2'h1: s_axi_rdata <= {busy_q, opc_q, 17'h0_0000, tmo_q, loaded_q, addr_q};
        2'h2: s_axi_rdata <= {24'h00_0000, buffer_q};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `EEP_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================================
  // Launch of an operation. The power-up image load goes first; a software
  // start arriving while busy is ignored rather than queued.
  assign swStart  = wrCmd && wStrb_q[3] && wData_q[`EEP_BUSY_BIT] && !busy_q;
  assign launch   = (state_q == EEP_ST_IDLE) && !busy_q && (bootPend_q || swStart);
  assign launchOp = bootPend_q ? EEP_OP_RELOAD :
                    eep_op_e'(wData_q[`EEP_OPC_MSB:`EEP_OPC_LSB]);
  // The address register only updates at the launch edge, so take the strobed bytes of the
  // starting write itself; otherwise the frame would go out to the previous address.
  assign launchAddr = {wStrb_q[1] ? wData_q[`EEP_ADDR_MSB] : addr_q[8],
                       wStrb_q[0] ? wData_q[7:0] : addr_q[7:0]};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bootPend_q <= 1'b1;
    end else if (launch) begin
      bootPend_q <= 1'b0;
    end
  end

  // Command fields; writes during an operation are ignored so the running
  // frame cannot be corrupted by a misbehaving driver.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      opc_q  <= `EEP_RST_OPC;
      addr_q <= `EEP_RST_ADDR;
    end else if (wrCmd && !busy_q) begin
      if (wStrb_q[3]) begin
        opc_q <= wData_q[`EEP_OPC_MSB:`EEP_OPC_LSB];
      end
      if (wStrb_q[1]) begin
        addr_q[8] <= wData_q[`EEP_ADDR_MSB];
      end
      if (wStrb_q[0]) begin
        addr_q[7:0] <= wData_q[7:0];
      end
    end
  end

  // Data byte: software fills it when idle, a finished read refills it.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      buffer_q <= `EEP_RST_DATA;
    end else if (state_q == EEP_ST_DONE && curOp_q == EEP_OP_READ) begin
      buffer_q <= shIn_q;
    end else if (wrData && !busy_q && wStrb_q[0]) begin
      buffer_q <= wData_q[`EEP_DATA_MSB:0];
    end
  end

  // Busy is set by the launch and clears itself when the engine finishes.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
    end else if (launch) begin
      busy_q <= 1'b1;
    end else if (state_q == EEP_ST_DONE) begin
      busy_q <= 1'b0;
    end
  end

  // Sticky flags, write one to clear; a set in the clearing cycle wins.
  // A failed reload touches nothing but leaves the loaded flag alone.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      loaded_q <= 1'b0;
    end else if (state_q == EEP_ST_DONE && curOp_q == EEP_OP_RELOAD &&
                 shIn_q == `EEP_SIGNATURE) begin
      loaded_q <= 1'b1;
    end else if (wrCmd && wStrb_q[1] && wData_q[`EEP_DL_BIT]) begin
      loaded_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tmo_q <= 1'b0;
    end else if (toHit) begin
      tmo_q <= 1'b1;
    end else if (wrCmd && wStrb_q[1] && wData_q[`EEP_TO_BIT]) begin
      tmo_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Serial clock divider, restarted at each launch so the first half period
  // is full length.
  assign tick = (divCnt_q == DIV_W'(SK_HALF - 1));

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_q <= '0;
    end else if (launch || tick) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= divCnt_q + DIV_W'(1);
    end
  end

  eep_sync #(
    .W (1)
  ) u_do_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .asyncIn  (eepDo),
    .syncOut  (doSync)
  );

  // Poll gives up when the device still reports busy at the last count.
  assign toHit = (state_q == EEP_ST_POLL) && tick && !doSync &&
                 (toCnt_q >= TO_W'(TIMEOUT_CYCLES - SK_HALF));

  // ==========================================================================
  // Serial engine. Data in is sampled at the end of each high phase; for a
  // read the last eight samples are the byte, after the dummy zero.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q  <= EEP_ST_IDLE;
      curOp_q  <= EEP_OP_READ;
      frame_q  <= '0;
      shIn_q   <= '0;
      bitCnt_q <= '0;
      nBits_q  <= '0;
      toCnt_q  <= '0;
      eepCs    <= 1'b0;
      eepSk    <= 1'b0;
      eepDi    <= 1'b0;
    end else begin
      case (state_q)
        EEP_ST_IDLE: begin
          if (launch) begin
            logic [19:0] f;
            f = buildFrame(launchOp, bootPend_q ? 9'h000 : launchAddr, buffer_q);
            curOp_q  <= launchOp;
            nBits_q  <= longFrame(launchOp) ? 5'h14 : 5'h0C;
            bitCnt_q <= '0;
            eepCs    <= 1'b1;
            eepSk    <= 1'b0;
            eepDi    <= f[19];
            frame_q  <= {f[18:0], 1'b0};
            state_q  <= EEP_ST_SHIFT;
          end
        end
        EEP_ST_SHIFT: begin
          if (tick && !eepSk) begin
            eepSk <= 1'b1;
          end else if (tick) begin
            eepSk  <= 1'b0;
            shIn_q <= {shIn_q[6:0], doSync};
            if (bitCnt_q == nBits_q - 5'h01) begin
              eepCs   <= 1'b0;
              eepDi   <= 1'b0;
              state_q <= EEP_ST_DESEL;
            end else begin
              bitCnt_q <= bitCnt_q + 5'h01;
              eepDi    <= frame_q[19];
              frame_q  <= {frame_q[18:0], 1'b0};
            end
          end
        end
        EEP_ST_DESEL: begin
          // Select stays low one half period before any ready poll.
          if (tick && needsPoll(curOp_q)) begin
            eepCs   <= 1'b1;
            toCnt_q <= '0;
            state_q <= EEP_ST_POLL;
          end else if (tick) begin
            state_q <= EEP_ST_DONE;
          end
        end
        EEP_ST_POLL: begin
          // A missing part with data in held low never reports ready.
          if (tick && (doSync || toHit)) begin
            eepCs   <= 1'b0;
            state_q <= EEP_ST_DONE;
          end else if (toCnt_q != TO_W'(TIMEOUT_CYCLES)) begin
            toCnt_q <= toCnt_q + TO_W'(1);
          end
        end
        EEP_ST_DONE: begin
          state_q <= EEP_ST_IDLE;
        end
        default: begin
          state_q <= EEP_ST_IDLE;
          eepCs   <= 1'b0;
        end
      endcase
    end
  end

endmodule

// file: eep_cfg.svh
`ifndef EEP_CFG_SVH
`define EEP_CFG_SVH

// ==========================================================================
// Register map (byte addresses on the AXI4-Lite port).
`define EEP_CMD_OFS       8'h40
`define EEP_DATA_OFS      8'h44

// ==========================================================================
// Field positions in the command/control word.
`define EEP_BUSY_BIT      31
`define EEP_OPC_MSB       30
`define EEP_OPC_LSB       28
`define EEP_TO_BIT        10
`define EEP_DL_BIT        9
`define EEP_ADDR_MSB      8
`define EEP_DATA_MSB      7

// ==========================================================================
// Reset values.
`define EEP_RST_OPC       3'h0
`define EEP_RST_ADDR      9'h000
`define EEP_RST_DATA      8'h00

// ==========================================================================
// Image signature and bus answers.
`define EEP_SIGNATURE     8'hA5
`define EEP_RESP_OKAY     2'h0
`define EEP_RESP_SLVERR   2'h2

// ==========================================================================
// Timing: core clock rate, busy timeout and serial clock half period.
`define EEP_CLK_HZ        40000000
`define EEP_TIMEOUT_MS    30
`define EEP_SK_HALF_CYC   20

`endif

// file: eep_pkg.sv
package eep_pkg;

  // ==========================================================================
  // Operation codes as held in the command field.
  typedef enum logic [2:0] {
    EEP_OP_READ   = 3'h0,
    EEP_OP_ERASE_WRITE_DISABLE_CMD   = 3'h1,
    EEP_OP_ERASE_WRITE_ENABLE_CMD   = 3'h2,
    EEP_OP_WRITE  = 3'h3,
    EEP_OP_WRITE_ALL_CMD   = 3'h4,
    EEP_OP_ERASE  = 3'h5,
    EEP_OP_ERASE_ALL_CMD   = 3'h6,
    EEP_OP_RELOAD = 3'h7
  } eep_op_e;

  // ==========================================================================
  // Serial engine states, Gray coded along idle-shift-deselect-poll-done.
  typedef enum logic [2:0] {
    EEP_ST_IDLE  = 3'h0,
    EEP_ST_SHIFT = 3'h1,
    EEP_ST_DESEL = 3'h3,
    EEP_ST_POLL  = 3'h2,
    EEP_ST_DONE  = 3'h6
  } eep_state_e;

endpackage

// file: eep_sync.sv
`timescale 1ns/1ps

module eep_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_q;

  // ==========================================================================
  // Two flops; the first is read only by the second to keep metastability out.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule

// file: eep_ctrl_assertions.sv
`timescale 1ns/1ps
`include "eep_cfg.svh"

module eep_ctrl_assertions #(
  parameter int ADDR_W  = 8,
  parameter int SK_HALF = 20
) (
  input wire logic              core_clk,
  input wire logic              rst_b,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              eepCs,
  input wire logic              eepSk,
  input wire logic              eepDi
);
  int hiCnt_q;

  // ====================
  // Counts core cycles of the current serial clock high phase.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hiCnt_q <= 0;
    end else if (eepSk) begin
      hiCnt_q <= hiCnt_q + 1;
    end else begin
      hiCnt_q <= 0;
    end
  end

  default clocking cbDef @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // ====================
  // Serial link shape.
  property p_sk_high_len; $fell(eepSk) |-> hiCnt_q == SK_HALF; endproperty
  a_sk_high_len: assert property (p_sk_high_len) else $error("serial clock high phase length");
  property p_frame_start; $rose(eepCs) |-> !eepSk; endproperty
  a_frame_start: assert property (p_frame_start) else $error("select rose with clock high");
  property p_di_steady; eepSk && $past(eepSk) |-> $stable(eepDi); endproperty
  a_di_steady: assert property (p_di_steady) else $error("data out moved in high phase");
  // A select that never drops means the poll never gave up.
  property p_frame_bound; $rose(eepCs) |-> ##[1:1000] !eepCs; endproperty
  a_frame_bound: assert property (p_frame_bound) else $error("select stuck high");

  // ====================
  // Register port answers.
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  // The response is issued on the edge after both halves are held, so it is seen two later.
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write response late");
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_r_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr != `EEP_CMD_OFS
      && s_axi_araddr != `EEP_DATA_OFS |=> s_axi_rresp == `EEP_RESP_SLVERR;
  endproperty
  a_r_unmapped: assert property (p_r_unmapped) else $error("unmapped read not refused");

  c_frame: cover property ($rose(eepCs));
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == `EEP_RESP_OKAY);
endmodule

bind eep_ctrl eep_ctrl_assertions #(.ADDR_W(ADDR_W), .SK_HALF(SK_HALF)) u_chk (.*);

// file: eep_mem_model.sv
`timescale 1ns/1ps

module eep_mem_model (
  input  wire logic eepCs,
  input  wire logic eepSk,
  input  wire logic eepDi,
  output logic      eepDo
);
  logic [7:0]  mem [512];
  logic        erase_write_enable_cmd;
  logic        present;
  logic        progBusy;
  logic        outBit;
  logic [19:0] shiftIn;
  logic [1:0]  opQ;
  logic [8:0]  adQ;
  int          cnt;
  logic        rdFrame;

  // ====================
  // Power-up: write protected, blank array with a valid signature at 0 and 3C at 012.
  initial begin
    erase_write_enable_cmd = 1'b0;
    present = 1'b1;
    progBusy = 1'b0;
    outBit = 1'b1;
    cnt = 0;
    foreach (mem[i]) mem[i] = 8'hFF;
    mem[0] = 8'hA5;
    mem[9'h012] = 8'h3C;
  end

  // Bits are clocked in on the rising serial clock while selected.
  always @(posedge eepCs) cnt = 0;
  always @(posedge eepSk) begin
    if (eepCs) begin
      shiftIn = {shiftIn[18:0], eepDi};
      cnt++;
      if (cnt == 12) begin
        opQ = shiftIn[10:9];
        adQ = shiftIn[8:0];
      end
    end
  end

  // Read data leaves on the falling clock so it is steady a whole bit.
  assign rdFrame = opQ == 2'b10 || (opQ == 2'b00 && adQ[8:7] == 2'b00);
  always @(negedge eepSk) begin
    if (eepCs && cnt >= 12 && cnt < 20 && rdFrame) outBit = mem[adQ][19-cnt];
  end

  // Instructions take effect when select drops; protected ones need enable.
  always @(negedge eepCs) begin
    if (cnt == 12 || cnt == 20) begin
      case (opQ)
        2'b01: if (erase_write_enable_cmd) {mem[adQ], progBusy} = {shiftIn[7:0], 1'b1};
        2'b11: if (erase_write_enable_cmd) {mem[adQ], progBusy} = {8'hFF, 1'b1};
        2'b00: case (adQ[8:7])
          2'b11: erase_write_enable_cmd = 1'b1;
          2'b00: if (cnt == 12) erase_write_enable_cmd = 1'b0;
          2'b01: if (erase_write_enable_cmd) begin
            foreach (mem[i]) mem[i] = shiftIn[7:0];
            progBusy = 1'b1;
          end
          default: if (erase_write_enable_cmd) begin
            foreach (mem[i]) mem[i] = 8'hFF;
            progBusy = 1'b1;
          end
        endcase
        default: ;
      endcase
    end
  end

  // Programming takes a while; the ready line stays low until it is over.
  always @(posedge progBusy) #3000 progBusy = 1'b0;
  // The line is pulled high when released, pulled low with no part fitted.
  assign eepDo = !present ? 1'b0 : !eepCs ? 1'b1 : (cnt >= 12 && rdFrame) ? outBit : !progBusy;
endmodule

// file: eep_ctrl_tb.sv
`timescale 1ns/1ps
`include "eep_cfg.svh"

module eep_ctrl_tb import eep_pkg::*;;
  logic        core_clk;
  logic        rst_b;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        eepCs;
  logic        eepSk;
  logic        eepDi;
  logic        eepDo;
  int          badCount;
  int          compares;

  // A serial half period of 4 cycles gives the 200 ns link clock.
  eep_ctrl #(.ADDR_W(8), .SK_HALF(4), .TIMEOUT_CYCLES(200)) dut (.*);
  eep_mem_model u_mem (.*);

  // ====================
  // Clock and checking helpers.
  always #12.5 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", badCount, compares);
    if (badCount == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ====================
  // Register port master: holds each channel until its own handshake. The answer
  // ready lines stay high between calls, so back-to-back calls never touch them twice
  // in one step; only the watchdog ends a wait.
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0]  r;
    axiRd(a, v, r);
    chk(v, e);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic waitIdle();
    logic [31:0] v;
    logic [1:0]  r;
    do begin
      axiRd(`EEP_CMD_OFS, v, r);
    end while (v[31] !== 1'b0);
  endtask

  // Starts one command, sees busy up, then waits and checks the final word.
  task automatic run(input eep_op_e op, input logic [8:0] a, input logic [1:0] fl);
    logic [31:0] v;
    logic [1:0]  r;
    axiWr(`EEP_CMD_OFS, {1'b1, op, 19'h0, a}, `EEP_RESP_OKAY);
    axiRd(`EEP_CMD_OFS, v, r);
    chk({31'h0, v[31]}, 32'h1);
    waitIdle();
    rdChk(`EEP_CMD_OFS, {1'b0, op, 17'h0, fl, a}, `EEP_RESP_OKAY);
  endtask

  // ====================
  // Main sequence.
  initial begin
    {core_clk, rst_b, s_axi_awaddr, s_axi_awvalid, s_axi_wdata} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    badCount = 0;
    compares = 0;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    waitIdle();
    rdChk(`EEP_CMD_OFS, 32'h0000_0200, `EEP_RESP_OKAY);
    axiWr(`EEP_CMD_OFS, 32'h0000_0200, `EEP_RESP_OKAY);
    rdChk(`EEP_CMD_OFS, 32'h0000_0000, `EEP_RESP_OKAY);
    axiWr(8'h48, 32'h0000_0001, `EEP_RESP_SLVERR);
    rdChk(8'h00, 32'h0000_0000, `EEP_RESP_SLVERR);
    run(EEP_OP_READ, 9'h012, 2'b00);
    rdChk(`EEP_DATA_OFS, 32'h0000_003C, `EEP_RESP_OKAY);
    axiWr(`EEP_DATA_OFS, 32'h0000_005A, `EEP_RESP_OKAY);
    run(EEP_OP_WRITE, 9'h1FF, 2'b00);
    run(EEP_OP_READ, 9'h1FF, 2'b00);
    rdChk(`EEP_DATA_OFS, 32'h0000_00FF, `EEP_RESP_OKAY);
    run(EEP_OP_ERASE_WRITE_ENABLE_CMD, 9'h000, 2'b00);
    axiWr(`EEP_DATA_OFS, 32'h0000_005A, `EEP_RESP_OKAY);
    run(EEP_OP_WRITE, 9'h1FF, 2'b00);
    run(EEP_OP_READ, 9'h1FF, 2'b00);
    rdChk(`EEP_DATA_OFS, 32'h0000_005A, `EEP_RESP_OKAY);
    run(EEP_OP_ERASE, 9'h1FF, 2'b00);
    run(EEP_OP_READ, 9'h1FF, 2'b00);
    rdChk(`EEP_DATA_OFS, 32'h0000_00FF, `EEP_RESP_OKAY);
    axiWr(`EEP_DATA_OFS, 32'h0000_0077, `EEP_RESP_OKAY);
    run(EEP_OP_WRITE_ALL_CMD, 9'h000, 2'b00);
    run(EEP_OP_READ, 9'h100, 2'b00);
    rdChk(`EEP_DATA_OFS, 32'h0000_0077, `EEP_RESP_OKAY);
    run(EEP_OP_RELOAD, 9'h000, 2'b00);
    rdChk(`EEP_DATA_OFS, 32'h0000_0077, `EEP_RESP_OKAY);
    run(EEP_OP_ERASE_ALL_CMD, 9'h000, 2'b00);
    run(EEP_OP_READ, 9'h000, 2'b00);
    rdChk(`EEP_DATA_OFS, 32'h0000_00FF, `EEP_RESP_OKAY);
    run(EEP_OP_ERASE_WRITE_DISABLE_CMD, 9'h000, 2'b00);
    axiWr(`EEP_DATA_OFS, 32'h0000_0011, `EEP_RESP_OKAY);
    run(EEP_OP_WRITE, 9'h005, 2'b00);
    run(EEP_OP_READ, 9'h005, 2'b00);
    rdChk(`EEP_DATA_OFS, 32'h0000_00FF, `EEP_RESP_OKAY);
    run(EEP_OP_ERASE_WRITE_ENABLE_CMD, 9'h000, 2'b00);
    axiWr(`EEP_DATA_OFS, 32'h0000_00A5, `EEP_RESP_OKAY);
    run(EEP_OP_WRITE, 9'h000, 2'b00);
    run(EEP_OP_RELOAD, 9'h000, 2'b01);
    // With no part fitted the ready poll never succeeds.
    u_mem.present <= 1'b0;
    run(EEP_OP_WRITE, 9'h003, 2'b11);
    u_mem.present <= 1'b1;
    axiWr(`EEP_CMD_OFS, 32'h0000_0600, `EEP_RESP_OKAY);
    rdChk(`EEP_CMD_OFS, 32'h0000_0000, `EEP_RESP_OKAY);
    conclude();
  end

  // Watchdog sized well above the roughly 5,000 cycles the tests need.
  initial begin
    repeat (40000) @(posedge core_clk);
    badCount++;
    conclude();
  end
endmodule
